// ---- verilog/card_host_regs.svh ----
// Purpose: Offsets, field positions, codes and reset values of the card host interface.
// Assumes: Byte addresses on an 8-bit register port, one 32-bit word per register.
// Notes: Definitions only.
`ifndef CARD_HOST_REGS_SVH
`define CARD_HOST_REGS_SVH
`define OFF_MODE 8'h04
`define OFF_DTOUT 8'h08
`define OFF_SLOT 8'h0c
`define OFF_ARG 8'h10
`define OFF_CMD 8'h14
`define OFF_BLK 8'h18
`define OFF_CSTOUT 8'h1c
`define OFF_RXDATA 8'h30
`define OFF_STATUS 8'h40
`define OFF_IEN 8'h44
`define OFF_IDIS 8'h48
`define OFF_IMASK 8'h4c
`define OFF_CONFIG 8'h54
`define OFF_WPMODE 8'he4
`define OFF_WPSTAT 8'he8
`define CMD_SPECIAL_CMD_FIELD_LSB 8
`define CMD_DIR_BIT 18
`define CMD_TRANSFER_COMMAND_FIELD_LSB 16
`define CMD_TRANSFER_KIND_FIELD_LSB 19
`define CMD_IOSP_LSB 24
`define SP_CCS_DISABLE 3'h3
`define SP_BOOT_REQ 3'h6
`define SP_BOOT_END 3'h7
`define TRANSFER_COMMAND_FIELD_START 2'h1
`define TRANSFER_KIND_FIELD_SDIO_BYTE 3'h4
`define TRANSFER_KIND_FIELD_SDIO_BLOCK 3'h5
`define BYTE_MODE_MAX 32'h0000_0200
`define ST_CMD_READY 0
`define ST_RX_READY 1
`define ST_SDIO_IRQ_LSB 8
`define ST_CSRCV 13
`define ST_TRANSFER_DONE_FLAG 27
`define WPSRC_LSB 8
`define CCSD_PATTERN 5'h01
`define FRAME_BITS 6'h30
`define STATUS_RESET 32'h0800_0001
`endif

// ---- verilog/card_host_pkg.sv ----
// Purpose: Types shared by the card host special-operation logic.
// Assumes: Constants live in card_host_regs.svh.
// Notes: Two card slots.
package card_host_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10,
    ST_BOOT = 2'b11
  } phase_e;
endpackage

// ---- verilog/sd_mmc_host_special_ops.sv ----
// Purpose: Special operations of a memory-card host: SDIO transfers, suspend and resume,
//   per-slot SDIO interrupts, CE-ATA completion signal, boot, transfer done, write protection.
// Assumes: Card clock, command and data lines come from another domain and are synchronised.
// Notes: Only the read data path is built; a write sequence ends when its command is sent.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module sd_mmc_host_special_ops (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic card_clk,
  input wire logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe,
  input wire logic dat0_in,
  input wire logic [1:0] dat1_in
);
  typedef struct packed {
    card_host_pkg::phase_e phase;
    logic [1:0] clk_s;
    logic clk_d;
    logic [1:0] cmd_s;
    logic [1:0] dat0_s;
    logic [1:0] dat1_a;
    logic [1:0] dat1_b;
    logic [31:0] mode;
    logic [31:0] dtout;
    logic [31:0] slot;
    logic [31:0] arg;
    logic [31:0] blk;
    logic [31:0] cstout;
    logic [31:0] config_reg;
    logic [1:0] imask;
    logic wp_en;
    logic wp_violation_flag;
    logic [15:0] wpsrc;
    logic rx_ready;
    logic transfer_done_flag;
    logic csrcv;
    logic [1:0] sdio_irq;
    logic ata_wait;
    logic [47:0] frame;
    logic [5:0] bits_left;
    logic rx_after;
    logic rx_started;
    logic [31:0] bytes_left;
    logic [4:0] bit_idx;
    logic [31:0] rx_word;
    logic [31:0] rx_data;
    logic cmd_out;
    logic cmd_oe;
    logic [31:0] rdata;
  } state_s;
  state_s cur;
  state_s next_cur;
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
    begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  function automatic logic is_protected(input logic [7:0] a);
    is_protected = (a == `OFF_MODE) || (a == `OFF_DTOUT) || (a == `OFF_SLOT) ||
      (a == `OFF_CSTOUT) || (a == `OFF_CONFIG);
  endfunction
  wire logic clk_rise = cur.clk_s[1] & ~cur.clk_d;
  wire logic [2:0] sp = wdata[`CMD_SPECIAL_CMD_FIELD_LSB +: 3];
  wire logic [2:0] transfer_kind_field = wdata[`CMD_TRANSFER_KIND_FIELD_LSB +: 3];
  wire logic [31:0] status = {4'h0, cur.transfer_done_flag, 13'h0000, cur.csrcv, 3'h0, cur.sdio_irq,
    6'h00, cur.rx_ready, cur.phase == card_host_pkg::ST_IDLE};
  always_comb
  begin
    next_cur = cur;
    next_cur.clk_s = {cur.clk_s[0], card_clk};
    next_cur.clk_d = cur.clk_s[1];
    next_cur.cmd_s = {cur.cmd_s[0], cmd_in};
    next_cur.dat0_s = {cur.dat0_s[0], dat0_in};
    next_cur.dat1_a = dat1_in;
    next_cur.dat1_b = cur.dat1_a;
    next_cur.rdata = 32'h0000_0000;
    if (rd)
    begin
      if (addr == `OFF_MODE)
        next_cur.rdata = cur.mode;
      else if (addr == `OFF_DTOUT)
        next_cur.rdata = cur.dtout;
      else if (addr == `OFF_SLOT)
        next_cur.rdata = cur.slot;
      else if (addr == `OFF_ARG)
        next_cur.rdata = cur.arg;
      else if (addr == `OFF_BLK)
        next_cur.rdata = cur.blk;
      else if (addr == `OFF_CSTOUT)
        next_cur.rdata = cur.cstout;
      else if (addr == `OFF_CONFIG)
        next_cur.rdata = cur.config_reg;
      else if (addr == `OFF_IMASK)
        next_cur.rdata = {22'h000000, cur.imask, 8'h00};
      else if (addr == `OFF_WPMODE)
        next_cur.rdata = {31'h00000000, cur.wp_en};
      else if (addr == `OFF_RXDATA)
      begin
        next_cur.rdata = cur.rx_data;
        next_cur.rx_ready = 1'b0;
      end
      else if (addr == `OFF_STATUS)
      begin
        next_cur.rdata = status;
        next_cur.csrcv = 1'b0;
        next_cur.sdio_irq = 2'b00;
      end
      else if (addr == `OFF_WPSTAT)
      begin
        next_cur.rdata = {8'h00, cur.wpsrc, 7'h00, cur.wp_violation_flag};
        next_cur.wp_violation_flag = 1'b0;
      end
    end
    // Slots enabled in imask are watched while idle; placed after the status read so that a new interrupt wins.
    for (int s = 0; s < 2; s++)
    begin
      if (!cur.dat1_b[s] && cur.imask[s] && cur.phase == card_host_pkg::ST_IDLE)
        next_cur.sdio_irq[s] = 1'b1;
    end
    if (wr)
    begin
      if (cur.wp_en && is_protected(addr))
      begin
        next_cur.wp_violation_flag = 1'b1;
        next_cur.wpsrc = {10'h000, addr[7:2]};
      end
      else if (addr == `OFF_MODE)
        next_cur.mode = wdata;
      else if (addr == `OFF_DTOUT)
        next_cur.dtout = wdata;
      else if (addr == `OFF_SLOT)
        next_cur.slot = wdata;
      else if (addr == `OFF_CSTOUT)
        next_cur.cstout = wdata;
      else if (addr == `OFF_CONFIG)
        next_cur.config_reg = wdata;
      else if (addr == `OFF_ARG)
        next_cur.arg = wdata;
      else if (addr == `OFF_BLK)
        next_cur.blk = wdata;
      else if (addr == `OFF_IEN)
        next_cur.imask = cur.imask | wdata[`ST_SDIO_IRQ_LSB +: 2];
      else if (addr == `OFF_IDIS)
        next_cur.imask = cur.imask & ~wdata[`ST_SDIO_IRQ_LSB +: 2];
      else if (addr == `OFF_WPMODE)
        next_cur.wp_en = wdata[0];
      else if (addr == `OFF_CMD && cur.phase == card_host_pkg::ST_IDLE)
      begin
        next_cur.transfer_done_flag = 1'b0;
        next_cur.cmd_oe = 1'b1;
        next_cur.cmd_out = 1'b1;
        next_cur.phase = card_host_pkg::ST_SEND;
        next_cur.rx_after = (wdata[`CMD_TRANSFER_COMMAND_FIELD_LSB +: 2] == `TRANSFER_COMMAND_FIELD_START) &&
          wdata[`CMD_DIR_BIT];
        next_cur.rx_started = 1'b0;
        next_cur.bit_idx = 5'h00;
        // Byte mode moves block count bytes, zero meaning the 512-byte maximum.
        if (transfer_kind_field == `TRANSFER_KIND_FIELD_SDIO_BYTE)
          next_cur.bytes_left = (cur.blk[15:0] == 16'h0000) ? `BYTE_MODE_MAX :
            {16'h0000, cur.blk[15:0]};
        else
          next_cur.bytes_left = cur.blk[15:0] * cur.blk[31:16];
        if (sp == `SP_BOOT_REQ)
        begin
          next_cur.cmd_out = 1'b0;
          next_cur.phase = card_host_pkg::ST_BOOT;
        end
        else if (sp == `SP_CCS_DISABLE)
        begin
          next_cur.frame = {`CCSD_PATTERN, 43'h0};
          next_cur.bits_left = 6'h05;
          next_cur.ata_wait = 1'b0;
          next_cur.rx_after = 1'b0;
        end
        else
        begin
          // Suspend and resume leave through this same frame path.
          next_cur.frame = {2'b01, wdata[5:0], cur.arg,
            crc7({2'b01, wdata[5:0], cur.arg}), 1'b1};
          next_cur.bits_left = `FRAME_BITS;
          next_cur.ata_wait = (wdata[5:0] == 6'h3d) && cur.config_reg[0];
        end
      end
    end
    case (cur.phase)
      card_host_pkg::ST_IDLE:
      begin
        if (cur.ata_wait && !cur.cmd_s[1])
        begin
          next_cur.csrcv = 1'b1;
          next_cur.ata_wait = 1'b0;
        end
      end
      card_host_pkg::ST_SEND:
      begin
        if (clk_rise)
        begin
          next_cur.cmd_out = cur.frame[47];
          next_cur.frame = {cur.frame[46:0], 1'b1};
          next_cur.bits_left = cur.bits_left - 6'h01;
          if (cur.bits_left == 6'h00)
          begin
            next_cur.cmd_oe = 1'b0;
            next_cur.cmd_out = 1'b1;
            if (cur.rx_after && cur.bytes_left != 32'h0)
              next_cur.phase = card_host_pkg::ST_RECV;
            else
            begin
              next_cur.phase = card_host_pkg::ST_IDLE;
              next_cur.transfer_done_flag = 1'b1;
            end
          end
        end
      end
      default:
      begin
        if (cur.phase == card_host_pkg::ST_BOOT && wr && addr == `OFF_CMD &&
          sp == `SP_BOOT_END)
        begin
          next_cur.cmd_oe = 1'b0;
          next_cur.cmd_out = 1'b1;
          next_cur.phase = card_host_pkg::ST_IDLE;
          next_cur.transfer_done_flag = 1'b1;
        end
        else if (clk_rise && cur.bytes_left != 32'h0)
        begin
          if (!cur.rx_started)
            next_cur.rx_started = !cur.dat0_s[1];
          else
          begin
            next_cur.rx_word = {cur.rx_word[30:0], cur.dat0_s[1]};
            next_cur.bit_idx = cur.bit_idx + 5'h01;
            if (cur.bit_idx[2:0] == 3'h7)
              next_cur.bytes_left = cur.bytes_left - 32'h1;
            if (cur.bit_idx == 5'h1f || (cur.bit_idx[2:0] == 3'h7 &&
              cur.bytes_left == 32'h1))
            begin
              next_cur.rx_data = {cur.rx_word[30:0], cur.dat0_s[1]};
              next_cur.rx_ready = 1'b1;
              next_cur.bit_idx = 5'h00;
              if (cur.bytes_left == 32'h1 && cur.phase == card_host_pkg::ST_RECV)
              begin
                next_cur.phase = card_host_pkg::ST_IDLE;
                next_cur.transfer_done_flag = 1'b1;
              end
            end
          end
        end
      end
    endcase
    if (!rst_n)
    begin
      next_cur = '0;
      next_cur.cmd_out = 1'b1;
      next_cur.transfer_done_flag = 1'(`STATUS_RESET >> `ST_TRANSFER_DONE_FLAG);
    end
  end
  always_ff @(posedge clk)
  begin
    cur <= next_cur;
  end
  assign rdata = cur.rdata;
  assign cmd_out = cur.cmd_out;
  assign cmd_oe = cur.cmd_oe;
  sequence boot_req_s;
    wr && addr == `OFF_CMD && sp == `SP_BOOT_REQ && cur.phase == card_host_pkg::ST_IDLE;
  endsequence
  sequence cmd_low_s;
    cmd_oe && !cmd_out;
  endsequence
  chk_boot_cmd_low: assert property (@(posedge clk) disable iff (!rst_n)
    boot_req_s |=> cmd_low_s) else $error("boot request did not pull command low");
  chk_boot_end_release: assert property (@(posedge clk) disable iff (!rst_n)
    cur.phase == card_host_pkg::ST_BOOT && wr && addr == `OFF_CMD && sp == `SP_BOOT_END
    |=> !cmd_oe && cur.transfer_done_flag) else $error("boot end did not release the line");
  chk_wp_block: assert property (@(posedge clk) disable iff (!rst_n)
    wr && cur.wp_en && addr == `OFF_DTOUT |=> cur.dtout == $past(cur.dtout))
    else $error("protected register changed");
  chk_wp_mode_hold: assert property (@(posedge clk) disable iff (!rst_n)
    wr && cur.wp_en && addr == `OFF_MODE |=> $stable(cur.mode))
    else $error("mode register written under protection");
  chk_wp_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    wr && cur.wp_en && is_protected(addr) |=> cur.wp_violation_flag && cur.wpsrc[5:0] == $past(addr[7:2]))
    else $error("violation not recorded");
  chk_wp_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rd && addr == `OFF_WPSTAT && !wr |=> !cur.wp_violation_flag) else $error("violation flag not cleared");
  chk_cmd_start: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == `OFF_CMD && sp != `SP_BOOT_REQ && cur.phase == card_host_pkg::ST_IDLE
    |=> cmd_oe ##1 cmd_oe) else $error("command did not start");
  chk_ccsd_length: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == `OFF_CMD && sp == `SP_CCS_DISABLE && cur.phase == card_host_pkg::ST_IDLE
    |=> cur.bits_left == 6'h05 && cur.frame[47:43] == `CCSD_PATTERN)
    else $error("completion signal disable not loaded");
  chk_irq_sample: assert property (@(posedge clk) disable iff (!rst_n)
    cur.phase == card_host_pkg::ST_IDLE && !cur.dat1_b[1] && cur.imask[1]
    |=> cur.sdio_irq[1]) else $error("slot interrupt missed");
  chk_done_once: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cur.transfer_done_flag) |-> cur.phase == card_host_pkg::ST_IDLE)
    else $error("transfer done while busy");
endmodule

// ---- testbench/card_model.sv ----
// Purpose: Card side of the link: bus clock, command capture, read data and completion signal.
// Assumes: Command line has a pull-up and the data line idles high.
// Notes: The bus clock runs only while run is high and always finishes a started high phase.
`timescale 1ns/1ps
module card_model (
  input wire logic run,
  input wire logic cmd_oe,
  input wire logic cmd_out,
  input wire logic cs_low,
  input wire logic tx_go,
  input wire logic [31:0] tx_word,
  output logic card_clk,
  output logic cmd_in,
  output logic dat0,
  output logic tx_busy,
  output logic [63:0] sh,
  output logic [7:0] got,
  output logic [7:0] frames
);
  logic [7:0] cnt;
  logic [5:0] tcnt;
  // The card pulls the released line low to signal completion.
  assign cmd_in = cmd_oe ? cmd_out : !cs_low;
  initial
  begin
    card_clk = 1'b0;
    {dat0, tx_busy, sh, got, frames, cnt, tcnt} = {1'b1, 1'b0, 64'h0, 8'h0, 8'h0, 8'h0, 6'h0};
    #3;
    forever
    begin
      #62.5;
      if (run || card_clk)
        card_clk = !card_clk;
    end
  end
  // Bits are taken mid-cell, from the start bit on, until the host releases the line.
  always @(negedge card_clk)
  begin
    if (cmd_oe && (cnt != 8'h00 || !cmd_in))
    begin
      sh <= {sh[62:0], cmd_in};
      cnt <= cnt + 8'h01;
    end
    else if (!cmd_oe && cnt != 8'h00)
    begin
      got <= cnt;
      cnt <= 8'h00;
      frames <= frames + 8'h01;
    end
    if (tcnt != 6'h00)
    begin
      dat0 <= tx_word[tcnt - 6'h01];
      tcnt <= tcnt - 6'h01;
    end
    else if (tx_busy)
    begin
      dat0 <= 1'b1;
      tx_busy <= 1'b0;
    end
    else if (tx_go)
    begin
      dat0 <= 1'b0;
      tx_busy <= 1'b1;
      tcnt <= 6'h20;
    end
  end
endmodule

// ---- testbench/sd_mmc_host_special_ops_tb.sv ----
// Purpose: Self-checking bench for the card host special operations.
// Assumes: Register reads are checked one cycle after the read strobe.
// Notes: Expected read data wait in a queue until the read result appears.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module sd_mmc_host_special_ops_tb;
  logic clk, rst_n, wr, rd, run, cs_low, tx_go, pend;
  logic cmd_out, cmd_oe, card_clk, cmd_in, dat0, tx_busy;
  logic [7:0] addr, got, frames, f0;
  logic [31:0] wdata, rdata, tx_word, seed;
  logic [1:0] dat1;
  logic [63:0] sh;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] prot [5] = '{8'h04, 8'h08, 8'h0c, 8'h1c, 8'h54};
  int fail_count, checks, cyc, i, k;
  sd_mmc_host_special_ops u_sd_mmc_host_special_ops (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .card_clk(card_clk), .cmd_in(cmd_in),
    .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat0_in(dat0), .dat1_in(dat1));
  card_model u_card_model (.run(run), .cmd_oe(cmd_oe), .cmd_out(cmd_out), .cs_low(cs_low),
    .tx_go(tx_go), .tx_word(tx_word), .card_clk(card_clk), .cmd_in(cmd_in), .dat0(dat0),
    .tx_busy(tx_busy), .sh(sh), .got(got), .frames(frames));
  initial clk = 1'b0;
  always #5 clk = !clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic test_done();
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic send_cmd(input logic [31:0] c, input logic keep);
    run = 1'b1;
    f0 = frames;
    wreg(`OFF_CMD, c);
    #1 chk(cmd_oe, 1'b1, "cmd_oe");
    for (i = 0; i < 2000 && frames == f0; i++)
      @(posedge clk);
    run = keep;
  endtask
  task automatic rx_word(input logic [31:0] w);
    run = 1'b1;
    tx_word = w;
    tx_go = 1'b1;
    for (i = 0; i < 600 && !tx_busy; i++)
      @(posedge clk);
    tx_go = 1'b0;
    for (i = 0; i < 600 && tx_busy; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    run = 1'b0;
  endtask
  always @(negedge clk)
  begin
    if (pend && exp_q.size() > 0)
    begin
      chk(rdata & msk_q[0], exp_q[0] & msk_q[0], "rdata");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    pend = rd;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    {rst_n, wr, rd, run, cs_low, tx_go, pend, addr, wdata, tx_word} = '0;
    dat1 = 2'h3;
    {fail_count, checks, cyc} = '0;
    seed = 32'h0000_002e;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`OFF_STATUS, `STATUS_RESET, 32'h0800_0003);
    wreg(`OFF_WPMODE, 32'h1);
    for (k = 0; k < 5; k++)
    begin
      wreg(prot[k], 32'h0000_00a5);
      rreg(prot[k], 32'h0, 32'hffff_ffff);
      rreg(`OFF_WPSTAT, {18'h0, prot[k][7:2], 8'h01}, 32'h00ff_ff01);
      rreg(`OFF_WPSTAT, 32'h0, 32'h1);
    end
    wreg(`OFF_WPMODE, 32'h0);
    wreg(`OFF_MODE, 32'h35);
    rreg(`OFF_MODE, 32'h35, 32'hff);
    seed = xs(seed);
    wreg(`OFF_ARG, seed);
    send_cmd(32'h05, 1'b0);
    chk(got, 8'd48, "frame length");
    chk(sh[47:8], {2'b01, 6'h05, seed}, "frame head");
    chk(sh[0], 1'b1, "frame end");
    rreg(`OFF_STATUS, 32'h0800_0000, 32'h0800_0000);
    // Byte mode ignores the length; block mode multiplies it.
    for (k = 0; k < 2; k++)
    begin
      wreg(`OFF_BLK, (k == 0) ? {16'h0007, 16'h0004} : {16'h0004, 16'h0001});
      send_cmd(32'h0105_0035 | (32'(k) << 19) | (32'(`TRANSFER_KIND_FIELD_SDIO_BYTE) << 19), 1'b1);
      rreg(`OFF_STATUS, 32'h0, 32'h0800_0002);
      seed = xs(seed);
      rx_word(seed);
      rreg(`OFF_STATUS, 32'h0800_0002, 32'h0800_0002);
      rreg(`OFF_RXDATA, seed, 32'hffff_ffff);
    end
    wreg(`OFF_SLOT, 32'h0);
    wreg(`OFF_IEN, 32'h200);
    dat1 <= 2'h0;
    repeat (6) @(posedge clk);
    rreg(`OFF_STATUS, 32'h200, 32'h300);
    dat1 <= 2'h3;
    repeat (6) @(posedge clk);
    // The line was still low after the first read, so the flag was raised once more.
    rreg(`OFF_STATUS, 32'h200, 32'h300);
    rreg(`OFF_STATUS, 32'h0, 32'h300);
    wreg(`OFF_CONFIG, 32'h1);
    send_cmd(32'h3c, 1'b0);
    send_cmd(32'h3d, 1'b0);
    send_cmd(32'(`SP_CCS_DISABLE) << `CMD_SPECIAL_CMD_FIELD_LSB, 1'b0);
    chk(got, 8'd5, "disable length");
    chk(sh[4:0], `CCSD_PATTERN, "disable pattern");
    send_cmd(32'h0c, 1'b0);
    send_cmd(32'h27, 1'b0);
    send_cmd(32'h00, 1'b0);
    chk(sh[45:40], 6'h00, "reset index");
    send_cmd(32'h3d, 1'b0);
    cs_low <= 1'b1;
    repeat (6) @(posedge clk);
    cs_low <= 1'b0;
    rreg(`OFF_STATUS, 32'h2000, 32'h2000);
    rreg(`OFF_STATUS, 32'h0, 32'h2000);
    wreg(`OFF_BLK, {16'h0200, 16'h0001});
    // The card model sends no boot acknowledge, so that command bit stays clear.
    wreg(`OFF_CMD, 32'h0005_0000 | (32'(`SP_BOOT_REQ) << `CMD_SPECIAL_CMD_FIELD_LSB));
    #1 chk({cmd_oe, cmd_out}, 2'b10, "boot hold");
    seed = xs(seed);
    rx_word(seed);
    rreg(`OFF_STATUS, 32'h2, 32'h0800_0002);
    rreg(`OFF_RXDATA, seed, 32'hffff_ffff);
    chk({cmd_oe, cmd_out}, 2'b10, "boot still");
    wreg(`OFF_CMD, 32'(`SP_BOOT_END) << `CMD_SPECIAL_CMD_FIELD_LSB);
    #1 chk({cmd_oe, cmd_out}, 2'b01, "boot end");
    rreg(`OFF_STATUS, 32'h0800_0000, 32'h0800_0000);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule
